// ==== core/tmr_conv_timer.sv ====
// tmr_conv_timer: times one conversion, length set by resolution
module tmr_conv_timer
    import tmr_pkg::*;
#(
    parameter int CONV9_LEN = CONV9_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // control
    input wire logic start,
    input wire logic [1:0] res,
    // status
    output logic busy,
    output logic done
);

    logic [CONV_CNT_W-1:0] remain;

    // ----------------------------------------------------------------
    // countdown
    // ----------------------------------------------------------------
    // length latched at start, so a resolution change mid-way
    // only affects the next conversion
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            remain <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                remain <= CONV_CNT_W'(CONV9_LEN) << res;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (remain <= CONV_CNT_W'(1))
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                remain <= remain - CONV_CNT_W'(1);
            end
        end
    end

endmodule : tmr_conv_timer

// ==== core/tmr_pkg.sv ====
// tmr_pkg: constants, types and helpers for the thermometer readout block
package tmr_pkg;

    // ----------------------------------------------------------------
    // register pointer codes
    // ----------------------------------------------------------------
    localparam logic [1:0] PTR_RESULT = 2'h0;
    localparam logic [1:0] PTR_CONFIG = 2'h1;
    localparam logic [1:0] PTR_HYST = 2'h2;
    localparam logic [1:0] PTR_UPPER = 2'h3;

    // ----------------------------------------------------------------
    // configuration bit positions
    // ----------------------------------------------------------------
    localparam int CFG_SHUTDOWN = 0;
    localparam int CFG_MODE = 1;
    localparam int CFG_POLARITY = 2;
    localparam int CFG_FAULT_LO = 3;
    localparam int CFG_RES_LO = 5;
    localparam int CFG_NV_BUSY = 7;

    // ----------------------------------------------------------------
    // factory values and field masks
    // ----------------------------------------------------------------
    localparam logic [15:0] FACTORY_UPPER = 16'h5000;
    localparam logic [15:0] FACTORY_HYST = 16'h4B00;
    localparam logic [6:0] FACTORY_CONFIG = 7'h00;
    localparam logic [15:0] TRIP_LAYOUT_MASK = 16'hFFF0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLOCK_KHZ = 10_000;
    localparam int CONV9_TIME_MS = 25;
    localparam int NV_COPY_TIME_MS = 10;
    localparam int CONV9_CYCLES = CONV9_TIME_MS * CLOCK_KHZ;
    localparam int NV_COPY_CYCLES = NV_COPY_TIME_MS * CLOCK_KHZ;
    localparam int CONV_CNT_W = 22;
    localparam int NV_CNT_W = 17;

    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_CONVERT = 2'b01,
        ST_STANDBY = 2'b10
    } tmr_state_t;

    // keeps the data bits selected by the resolution code
    function automatic logic [15:0] tmr_res_mask(input logic [1:0] res);
        logic [15:0] m;
        m = 16'hFF80;
        unique case (res)
            2'h0: m = 16'hFF80;
            2'h1: m = 16'hFFC0;
            2'h2: m = 16'hFFE0;
            2'h3: m = 16'hFFF0;
        endcase
        return m;
    endfunction : tmr_res_mask

    // consecutive faults needed for each fault code
    function automatic logic [2:0] tmr_fault_limit(input logic [1:0] sel);
        logic [2:0] n;
        n = 3'h1;
        unique case (sel)
            2'h0: n = 3'h1;
            2'h1: n = 3'h2;
            2'h2: n = 3'h4;
            2'h3: n = 3'h6;
        endcase
        return n;
    endfunction : tmr_fault_limit

endpackage : tmr_pkg

// ==== core/tmr_readout.sv ====
// tmr_readout: result, trip points, configuration and alarm of the thermometer
module tmr_readout
    import tmr_pkg::*;
#(
    parameter int CONV9_LEN = CONV9_CYCLES,
    parameter int NV_COPY_LEN = NV_COPY_CYCLES
)
(
    // clock and resets
    input wire logic mclk,
    input wire logic reset,
    input wire logic factory_reset,
    // register port from the serial engine
    input wire logic [1:0] reg_ptr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // nonvolatile commit command
    input wire logic nv_commit,
    // converter sample, 1/16 degree steps, signed
    input wire logic [11:0] adc_temp,
    // status
    output logic conv_active,
    output logic standby,
    // open-drain alarm pin
    input wire logic alarm_pin_in,
    output logic alarm_pin_out,
    output logic alarm_pin_oe
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    tmr_state_t state;
    logic [15:0] result;
    logic [15:0] sh_upper;
    logic [15:0] sh_hyst;
    logic [6:0] sh_config;
    logic [15:0] nv_upper;
    logic [15:0] nv_hyst;
    logic [6:0] nv_config;
    logic nv_busy_flag;
    logic [NV_CNT_W-1:0] nv_remain;
    logic conv_start;
    logic conv_busy;
    logic conv_done;
    logic alarm_active;
    logic expect_low;
    logic [2:0] fault_cnt;
    logic [1:0] resolution_sel;
    logic [1:0] fault_count_sel;
    logic shutdown_select;
    logic thermostat_mode_select;
    logic alarm_polarity;
    logic [15:0] res_mask;
    logic [15:0] next_result;
    logic above_upper;
    logic below_hyst;
    logic [2:0] fault_limit;
    logic [2:0] next_fault_cnt;
    logic enter_shutdown;

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    // fields come from the shadow copy, so host writes act at once
    assign shutdown_select = sh_config[CFG_SHUTDOWN];
    assign thermostat_mode_select = sh_config[CFG_MODE];
    assign alarm_polarity = sh_config[CFG_POLARITY];
    assign fault_count_sel = sh_config[CFG_FAULT_LO +: 2];
    assign resolution_sel = sh_config[CFG_RES_LO +: 2];

    // ----------------------------------------------------------------
    // conversion timing
    // ----------------------------------------------------------------
    // conversions repeat while the sequencer is converting, with a two-cycle gap
    assign conv_start = (state == ST_CONVERT) && !conv_busy && !conv_done;

    tmr_conv_timer #(
        .CONV9_LEN(CONV9_LEN)
    ) u_timer (
        .mclk(mclk),
        .reset(reset),
        .start(conv_start),
        .res(resolution_sel),
        .busy(conv_busy),
        .done(conv_done)
    );

    // ----------------------------------------------------------------
    // result formatting and limit compare
    // ----------------------------------------------------------------
    // twelve converter bits, cut here to the resolution so low bits read zero
    assign res_mask = tmr_res_mask(resolution_sel);
    assign next_result = {adc_temp, 4'h0} & res_mask;

    // signed strict compare against the truncated trip values
    assign above_upper = $signed(next_result) > $signed(sh_upper & res_mask);
    assign below_hyst = $signed(next_result) < $signed(sh_hyst & res_mask);
    assign fault_limit = tmr_fault_limit(fault_count_sel);
    assign next_fault_cnt = 3'(fault_cnt + 3'h1);

    // shutdown is entered when a conversion completes with the bit set
    assign enter_shutdown = conv_done && shutdown_select;

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    // reset starts in converting, so power-up in shutdown still measures once
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= ST_CONVERT;
        end
        else
        begin
            unique case (state)
                ST_CONVERT:
                begin
                    if (enter_shutdown)
                    begin
                        state <= ST_STANDBY;
                    end
                end
                ST_STANDBY:
                begin
                    if (!shutdown_select)
                    begin
                        state <= ST_CONVERT;
                    end
                end
                default:
                begin
                    state <= ST_CONVERT;
                end
            endcase
        end
    end

    assign conv_active = conv_busy;
    assign standby = (state == ST_STANDBY);

    // ----------------------------------------------------------------
    // result register
    // ----------------------------------------------------------------
    // only a finished conversion writes it; reads never reach the converter
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            result <= 16'h0000;
        end
        else if (conv_done)
        begin
            result <= next_result;
        end
    end

    // ----------------------------------------------------------------
    // nonvolatile cells
    // ----------------------------------------------------------------
    // survive the ordinary reset; only the factory reset reloads shipped values
    always_ff @(posedge mclk)
    begin
        if (factory_reset)
        begin
            nv_upper <= FACTORY_UPPER;
            nv_hyst <= FACTORY_HYST;
            nv_config <= FACTORY_CONFIG;
        end
        else if (nv_commit && !nv_busy_flag)
        begin
            nv_upper <= sh_upper;
            nv_hyst <= sh_hyst;
            nv_config <= sh_config;
        end
    end

    // copy timer; a commit while busy is ignored, the cells are being written
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            nv_busy_flag <= 1'b0;
            nv_remain <= '0;
        end
        else if (nv_commit && !nv_busy_flag)
        begin
            nv_busy_flag <= 1'b1;
            nv_remain <= NV_CNT_W'(NV_COPY_LEN);
        end
        else if (nv_busy_flag)
        begin
            if (nv_remain <= NV_CNT_W'(1))
            begin
                nv_busy_flag <= 1'b0;
            end
            nv_remain <= nv_remain - NV_CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // shadow registers
    // ----------------------------------------------------------------
    // reset reloads shadows from the cells: committed values become power-up state
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sh_upper <= nv_upper;
            sh_hyst <= nv_hyst;
            sh_config <= nv_config;
        end
        else if (reg_wr)
        begin
            unique case (reg_ptr)
                PTR_CONFIG:
                begin
                    sh_config <= reg_wdata[6:0];
                end
                PTR_HYST:
                begin
                    sh_hyst <= reg_wdata & TRIP_LAYOUT_MASK;
                end
                PTR_UPPER:
                begin
                    sh_upper <= reg_wdata & TRIP_LAYOUT_MASK;
                end
                PTR_RESULT:
                begin
                    // result is read-only; write dropped
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // the configuration byte sits in the low lane, upper lane zero
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            unique case (reg_ptr)
                PTR_RESULT:
                begin
                    reg_rdata <= result;
                end
                PTR_CONFIG:
                begin
                    reg_rdata <= {8'h00, nv_busy_flag, sh_config};
                end
                PTR_HYST:
                begin
                    reg_rdata <= sh_hyst;
                end
                PTR_UPPER:
                begin
                    reg_rdata <= sh_upper;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // thermostat
    // ----------------------------------------------------------------
    // a read clear loses to a same-cycle set; shutdown entry never sets in interrupt mode
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            alarm_active <= 1'b0;
            expect_low <= 1'b0;
            fault_cnt <= 3'h0;
        end
        else
        begin
            if (thermostat_mode_select && (reg_rd || enter_shutdown))
            begin
                alarm_active <= 1'b0;
            end
            if (conv_done)
            begin
                if (!thermostat_mode_select)
                begin
                    if (alarm_active)
                    begin
                        if (below_hyst)
                        begin
                            alarm_active <= 1'b0;
                        end
                        fault_cnt <= 3'h0;
                    end
                    else if (above_upper)
                    begin
                        if (next_fault_cnt >= fault_limit)
                        begin
                            alarm_active <= 1'b1;
                            fault_cnt <= 3'h0;
                        end
                        else
                        begin
                            fault_cnt <= next_fault_cnt;
                        end
                    end
                    else
                    begin
                        fault_cnt <= 3'h0;
                    end
                end
                else if (!alarm_active && !enter_shutdown)
                begin
                    // interrupt mode waits for a clear, then the opposite limit
                    if (expect_low ? below_hyst : above_upper)
                    begin
                        if (next_fault_cnt >= fault_limit)
                        begin
                            alarm_active <= 1'b1;
                            expect_low <= !expect_low;
                            fault_cnt <= 3'h0;
                        end
                        else
                        begin
                            fault_cnt <= next_fault_cnt;
                        end
                    end
                    else
                    begin
                        fault_cnt <= 3'h0;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // alarm pin
    // ----------------------------------------------------------------
    // open drain: only pulls low, so enable is high when the wanted level is low
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            alarm_pin_oe <= 1'b0;
        end
        else
        begin
            alarm_pin_oe <= alarm_active ^ alarm_polarity;
        end
    end

    assign alarm_pin_out = 1'b0;

    // pin level read back is not used inside; kept for the pad model
    logic unused_pin;
    assign unused_pin = alarm_pin_in;

endmodule : tmr_readout

// ==== verif/tb_top.sv ====
// tb_top: self-checking bench for the thermometer readout block
module tb_top;
    import tmr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic factory_reset = 1'b1;
    logic [11:0] adc_temp = 12'h000;
    logic [1:0] reg_ptr;
    logic reg_wr, reg_rd, nv_commit, conv_active, standby, alarm_pin_out, alarm_pin_oe;
    logic [15:0] reg_wdata, reg_rdata, v;
    int num_errors = 0;
    int total_checks = 0;
    int len;
    logic [31:0] rng = 32'd76;
    int lim[4] = '{1, 2, 4, 6};

    always #50 mclk = ~mclk;

    tmr_readout #(.CONV9_LEN(20), .NV_COPY_LEN(10)) tmr_readout_i (.mclk(mclk),
        .reset(reset), .factory_reset(factory_reset), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .nv_commit(nv_commit), .adc_temp(adc_temp), .conv_active(conv_active),
        .standby(standby), .alarm_pin_in(1'b1), .alarm_pin_out(alarm_pin_out),
        .alarm_pin_oe(alarm_pin_oe));
    tmr_host_model #(.GAP(1)) tmr_host_model_i (.mclk(mclk), .reg_ptr(reg_ptr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .nv_commit(nv_commit));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // integer model of a stored result: sixteenths cut to the resolution
    function automatic logic [15:0] model_res(input int t, input int r);
        return 16'((t << 4) & ~((1 << (7 - r)) - 1));
    endfunction : model_res

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // waits for the end of the next conversion; len counts its cycles
    task automatic conv_end();
        int n;
        n = 0;
        while (conv_active !== 1'b1 && n < 3000)
        begin
            @(negedge mclk);
            n++;
        end
        len = 0;
        while (conv_active === 1'b1 && n < 3000)
        begin
            @(negedge mclk);
            n++;
            len++;
        end
        if (n >= 3000)
        begin
            num_errors++;
            close_out();
        end
        repeat (2) @(negedge mclk); // result and pin settle
    endtask : conv_end

    // standby must last with no conversion at all
    task automatic idle_check();
        int hits;
        hits = 0;
        repeat (100)
        begin
            @(negedge mclk);
            hits += (conv_active !== 1'b0 || standby !== 1'b1);
        end
        check("idle", 16'(hits), 16'h0000);
    endtask : idle_check

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        // factory load drops one edge before the reset
        repeat (15) @(negedge mclk);
        factory_reset = 1'b0;
        @(negedge mclk);
        reset = 1'b0;
        tmr_host_model_i.rd(PTR_CONFIG, v);
        check("cfg_default", v, 16'h0000);
        tmr_host_model_i.rd(PTR_UPPER, v);
        check("upper_default", v, 16'h5000);
        tmr_host_model_i.rd(PTR_HYST, v);
        check("hyst_default", v, 16'h4B00);
        check("pin_idle", 16'(alarm_pin_oe), 16'h0000);
        tmr_host_model_i.wr(PTR_UPPER, 16'h1234);
        tmr_host_model_i.rd(PTR_UPPER, v);
        check("upper_nibble", v, 16'h1230);
        tmr_host_model_i.wr(PTR_CONFIG, 16'h00FF);
        tmr_host_model_i.rd(PTR_CONFIG, v);
        check("cfg_busy_ro", v, 16'h007F);
        tmr_host_model_i.wr(PTR_CONFIG, 16'h0000);
        // every resolution: length and masking of the stored result
        for (int r = 0; r < 4; r++)
        begin
            tmr_host_model_i.wr(PTR_CONFIG, 16'(r << 5));
            rng = xs(rng);
            adc_temp = rng[11:0];
            conv_end();
            conv_end();
            check("conv_len", 16'(len), 16'(20 << r));
            tmr_host_model_i.rd(PTR_RESULT, v);
            check("result", v, model_res(adc_temp, r));
        end
        // comparator mode, every fault count, then hysteresis hold
        tmr_host_model_i.wr(PTR_UPPER, 16'h1000);
        tmr_host_model_i.wr(PTR_HYST, 16'h0800);
        for (int f = 0; f < 4; f++)
        begin
            tmr_host_model_i.wr(PTR_CONFIG, 16'(f << 3));
            adc_temp = 12'h040;
            conv_end();
            conv_end();
            adc_temp = 12'h200;
            for (int k = 1; k <= lim[f]; k++)
            begin
                conv_end();
                check("fault_count", 16'(alarm_pin_oe), 16'(k == lim[f]));
            end
            adc_temp = 12'h0C0;
            conv_end();
            check("cmp_hold", 16'(alarm_pin_oe), 16'h0001);
            adc_temp = 12'h040;
            conv_end();
            check("cmp_clear", 16'(alarm_pin_oe), 16'h0000);
        end
        // just above the trip: ignored at 9 bits, seen at 12 bits, one fault each
        tmr_host_model_i.wr(PTR_CONFIG, 16'h0000);
        adc_temp = 12'h107;
        conv_end();
        check("trunc_9", 16'(alarm_pin_oe), 16'h0000);
        tmr_host_model_i.wr(PTR_CONFIG, 16'h0060);
        conv_end();
        conv_end();
        check("trunc_12", 16'(alarm_pin_oe), 16'h0001);
        // active-high polarity releases the pin while alarmed
        tmr_host_model_i.wr(PTR_CONFIG, 16'h0004);
        conv_end();
        check("polarity", 16'(alarm_pin_oe), 16'h0000);
        // interrupt mode: set, read clear, alternate limit, shutdown clear
        adc_temp = 12'h040;
        tmr_host_model_i.wr(PTR_CONFIG, 16'h0002);
        conv_end();
        conv_end();
        tmr_host_model_i.rd(PTR_HYST, v);
        adc_temp = 12'h200;
        conv_end();
        check("int_set", 16'(alarm_pin_oe), 16'h0001);
        tmr_host_model_i.rd(PTR_HYST, v);
        @(negedge mclk);
        check("int_rd_clear", 16'(alarm_pin_oe), 16'h0000);
        conv_end();
        check("int_no_repeat", 16'(alarm_pin_oe), 16'h0000);
        adc_temp = 12'h040;
        conv_end();
        check("int_hyst", 16'(alarm_pin_oe), 16'h0001);
        tmr_host_model_i.wr(PTR_CONFIG, 16'h0003);
        conv_end();
        check("sd_clear", 16'(alarm_pin_oe), 16'h0000);
        idle_check();
        tmr_host_model_i.rd(PTR_RESULT, v);
        check("sd_result", v, 16'h0400);
        tmr_host_model_i.wr(PTR_CONFIG, 16'h0000);
        conv_end();
        check("resume", 16'(len), 16'd20);
        // commit, then power up in shutdown from committed values
        tmr_host_model_i.wr(PTR_UPPER, 16'h2340);
        tmr_host_model_i.wr(PTR_CONFIG, 16'h0001);
        tmr_host_model_i.commit();
        tmr_host_model_i.rd(PTR_CONFIG, v);
        check("nv_busy", v, 16'h0081);
        repeat (20) @(negedge mclk);
        tmr_host_model_i.rd(PTR_CONFIG, v);
        check("nv_idle", v, 16'h0001);
        tmr_host_model_i.wr(PTR_UPPER, 16'h0000);
        reset = 1'b1;
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        rng = xs(rng);
        adc_temp = rng[11:0];
        tmr_host_model_i.rd(PTR_UPPER, v);
        check("nv_upper", v, 16'h2340);
        tmr_host_model_i.rd(PTR_CONFIG, v);
        check("nv_cfg", v, 16'h0001);
        conv_end();
        idle_check();
        tmr_host_model_i.rd(PTR_RESULT, v);
        check("one_shot", v, model_res(adc_temp, 0));
        close_out();
    end
endmodule : tb_top

// ==== verif/tmr_host_model.sv ====
// tmr_host_model: host side of the register port, prompt or slow by GAP
module tmr_host_model #(
    parameter int GAP = 0
)
(
    // clock
    input wire logic mclk,
    // register port
    output logic [1:0] reg_ptr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // commit command
    output logic nv_commit
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // bus cycles, driven at the falling edge
    // ----------------------------------------------------------------
    initial
    begin
        reg_ptr = 2'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        nv_commit = 1'b0;
    end

    // host writes; a zero shutdown bit resumes conversions
    task automatic wr(input logic [1:0] p, input logic [15:0] d);
        repeat (GAP) @(negedge mclk);
        @(negedge mclk);
        reg_ptr = p;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // released data must not look valid
    endtask : wr

    // any read also clears an interrupt-mode alarm
    task automatic rd(input logic [1:0] p, output logic [15:0] d);
        repeat (GAP) @(negedge mclk);
        @(negedge mclk);
        reg_ptr = p;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    // commit the shadows to nonvolatile cells
    task automatic commit();
        @(negedge mclk);
        nv_commit = 1'b1;
        @(negedge mclk);
        nv_commit = 1'b0;
    endtask : commit
endmodule : tmr_host_model

// ==== verif/tmr_readout_monitor.sv ====
// tmr_readout_monitor: port-level assertions for the thermometer readout
module tmr_readout_monitor
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [1:0] reg_ptr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    // status and alarm pin
    input wire logic conv_active,
    input wire logic standby,
    input wire logic alarm_pin_out,
    input wire logic alarm_pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // assertions, all in the mclk domain
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_result_low_zero: assert property (
        reg_rd && reg_ptr == PTR_RESULT |=> reg_rdata[3:0] == 4'h0)
        else $error("result low nibble not zero");
    a_trip_low_zero: assert property (
        reg_rd && reg_ptr[1] |=> reg_rdata[3:0] == 4'h0)
        else $error("trip point low nibble not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_pin_open_drain: assert property (alarm_pin_out == 1'b0)
        else $error("alarm pin drives high");
    a_standby_idle: assert property (standby |-> !conv_active)
        else $error("conversion running in standby");
    // no conversions in standby, so without writes or reads the pin cannot move
    a_standby_pin_still: assert property (
        standby && !reg_wr && !reg_rd && $past(standby) && !$past(reg_wr) && !$past(reg_rd)
        |=> $stable(alarm_pin_oe))
        else $error("alarm pin moved in standby");
    a_conv_min_len: assert property ($rose(conv_active) |-> conv_active [*8])
        else $error("conversion shorter than eight cycles");
    a_upper_write_back: assert property (
        reg_wr && reg_ptr == PTR_UPPER ##1 !reg_wr [*2]
        ##1 reg_rd && !reg_wr && reg_ptr == PTR_UPPER
        |=> reg_rdata == ($past(reg_wdata, 4) & 16'hFFF0))
        else $error("upper trip read back wrong");
    a_config_write_back: assert property (
        reg_wr && reg_ptr == PTR_CONFIG ##1 !reg_wr [*2]
        ##1 reg_rd && !reg_wr && reg_ptr == PTR_CONFIG
        |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 4) && reg_rdata[15:8] == 8'h00)
        else $error("configuration read back wrong");
endmodule : tmr_readout_monitor

bind tmr_readout tmr_readout_monitor tmr_readout_monitor_i (.mclk(mclk), .reset(reset),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conv_active(conv_active), .standby(standby),
    .alarm_pin_out(alarm_pin_out), .alarm_pin_oe(alarm_pin_oe));
